// >>> bench/fcsl_core_test.sv
// fcsl_core_test: self-checking bench for the flash command and status logic.
// assumes: fcsl_pkg compiled first; the bench is the only apb master.
`timescale 1ns/10ps
`default_nettype none
module fcsl_core_test
  import fcsl_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic protect_hit = 1'b0;
  logic verify_blank = 1'b1;
  logic cpu_stop = 1'b0;
  logic array_busy;
  logic irq_buffer_empty;
  logic irq_command_complete;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err_seen;
  logic [6:0] codes [5] = '{CMD_ERASE_VERIFY, CMD_PROGRAM, CMD_BURST_PROGRAM, CMD_SECTOR_ERASE, CMD_MASS_ERASE};

  always #20 pclk = ~pclk;

  fcsl_core DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .protect_hit(protect_hit), .verify_blank(verify_blank), .cpu_stop(cpu_stop),
    .array_busy(array_busy), .irq_buffer_empty(irq_buffer_empty),
    .irq_command_complete(irq_command_complete));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] mask,
                        input logic [7:0] exp);
    apb(a, 1'b0, 8'h00);
    chk(what, exp, rd[7:0] & mask);
  endtask

  task automatic run_cmd(input logic [7:0] code);
    apb(ADDR_ARRAY, 1'b1, 8'h00);
    apb(ADDR_COMMAND, 1'b1, code);
    apb(ADDR_STATUS, 1'b1, 8'h80);
  endtask

  // polls the complete flag; a hang here counts as a mismatch
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(ADDR_STATUS, 1'b0, 8'h00);
      n++;
    end while (rd[6] !== 1'b1 && n < 100);
    chk("complete wait", 8'h01, {7'h0, rd[6]});
  endtask

  task automatic stop_pulse();
    @(posedge pclk);
    cpu_stop <= 1'b1;
    @(posedge pclk);
    cpu_stop <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #(40 * 20000);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("status reset", ADDR_STATUS, 8'hFF, 8'hC0);
    apb(ADDR_RSV_ONE, 1'b1, 8'hFF);
    rd_chk("reserved", ADDR_RSV_ONE, 8'hFF, 8'h00);
    apb(12'h000, 1'b0, 8'h00);
    chk("unmapped err", 8'h01, {7'h0, err_seen});
    // launch before the divider is written must error out
    run_cmd(8'h20);
    repeat (4) @(posedge pclk);
    chk("busy no div", 8'h00, {7'h0, array_busy});
    apb(ADDR_STATUS, 1'b1, 8'h00);
    rd_chk("access_error_flag zero w", ADDR_STATUS, 8'hFF, 8'hD0);
    apb(ADDR_STATUS, 1'b1, 8'h10);
    rd_chk("access_error_flag clear", ADDR_STATUS, 8'hFF, 8'hC0);
    apb(ADDR_CLKDIV, 1'b1, 8'h10);
    apb(ADDR_CONFIG, 1'b1, 8'hC0);
    // the enables land at the access edge; look once they have settled
    @(negedge pclk);
    chk("irq be", 8'h01, {7'h0, irq_buffer_empty});
    chk("irq cc", 8'h01, {7'h0, irq_command_complete});
    // bit 7 of the command is dropped, leaving a valid program code
    apb(ADDR_ARRAY, 1'b1, 8'h00);
    apb(ADDR_COMMAND, 1'b1, 8'hA0);
    rd_chk("command", ADDR_COMMAND, 8'hFF, 8'h20);
    apb(ADDR_STATUS, 1'b1, 8'h80);
    rd_chk("cc after launch", ADDR_STATUS, 8'h40, 8'h00);
    chk("irq cc busy", 8'h00, {7'h0, irq_command_complete});
    wait_done();
    // all five codes accepted; launch clears a prior blank result
    foreach (codes[i]) begin
      run_cmd({1'b0, codes[i]});
      wait_done();
      chk("status code", (i == 0) ? 8'hC4 : 8'hC0, rd[7:0]);
    end
    // chained bursts keep complete low, writes to it do nothing
    run_cmd({1'b0, CMD_BURST_PROGRAM});
    run_cmd({1'b0, CMD_BURST_PROGRAM});
    apb(ADDR_STATUS, 1'b1, 8'h40);
    repeat (16) @(posedge pclk);
    rd_chk("burst cc", ADDR_STATUS, 8'h40, 8'h00);
    wait_done();
    chk("burst end", 8'hC0, rd[7:0]);
    // failed erase verify sets fail, cleared by a one
    verify_blank <= 1'b0;
    run_cmd({1'b0, CMD_ERASE_VERIFY});
    wait_done();
    chk("verify fail", 8'hC2, rd[7:0]);
    apb(ADDR_STATUS, 1'b1, 8'h02);
    rd_chk("fail clear", ADDR_STATUS, 8'hFF, 8'hC0);
    verify_blank <= 1'b1;
    run_cmd({1'b0, CMD_ERASE_VERIFY});
    wait_done();
    apb(ADDR_STATUS, 1'b1, 8'h04);
    rd_chk("blank normal", ADDR_STATUS, 8'hFF, 8'hC4);
    apb(ADDR_CONFIG, 1'b1, 8'h01);
    @(negedge pclk);
    chk("irq off", 8'h00, {6'h0, irq_buffer_empty, irq_command_complete});
    apb(ADDR_STATUS, 1'b1, 8'h04);
    rd_chk("blank special", ADDR_STATUS, 8'hFF, 8'hC0);
    // special mode takes any code; fail is first checked to read clear
    rd_chk("fail before special", ADDR_STATUS, 8'h02, 8'h00);
    run_cmd(8'h7F);
    wait_done();
    chk("special code", 8'hC0, rd[7:0]);
    rd_chk("special cmd", ADDR_COMMAND, 8'hFF, 8'h7F);
    apb(ADDR_CONFIG, 1'b1, 8'h00);
    // sequence faults
    apb(ADDR_ARRAY, 1'b1, 8'h00);
    apb(ADDR_STATUS, 1'b1, 8'h00);
    rd_chk("abort", ADDR_STATUS, 8'hFF, 8'hD0);
    apb(ADDR_STATUS, 1'b1, 8'h10);
    apb(ADDR_STATUS, 1'b1, 8'h00);
    rd_chk("zero idle", ADDR_STATUS, 8'hFF, 8'hC0);
    apb(ADDR_ARRAY, 1'b1, 8'h00);
    apb(ADDR_COMMAND, 1'b1, 8'h7F);
    rd_chk("bad code", ADDR_STATUS, 8'h10, 8'h10);
    apb(ADDR_STATUS, 1'b1, 8'h10);
    stop_pulse();
    rd_chk("stop idle", ADDR_STATUS, 8'hFF, 8'hC0);
    run_cmd(8'h20);
    stop_pulse();
    wait_done();
    chk("stop busy", 8'hD0, rd[7:0]);
    run_cmd(8'h20);
    repeat (4) @(posedge pclk);
    chk("access_error_flag blocks", 8'h00, {7'h0, array_busy});
    apb(ADDR_STATUS, 1'b1, 8'h10);
    protect_hit <= 1'b1;
    apb(ADDR_ARRAY, 1'b1, 8'h00);
    protect_hit <= 1'b0;
    rd_chk("protection_violation_flag", ADDR_STATUS, 8'hFF, 8'hE0);
    run_cmd(8'h20);
    repeat (4) @(posedge pclk);
    chk("protection_violation_flag blocks", 8'h00, {7'h0, array_busy});
    apb(ADDR_STATUS, 1'b1, 8'h00);
    rd_chk("both set", ADDR_STATUS, 8'hFF, 8'hF0);
    apb(ADDR_STATUS, 1'b1, 8'h30);
    rd_chk("both clear", ADDR_STATUS, 8'hFF, 8'hC0);
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> core/fcsl_core.sv
// fcsl_core: flash status flags, command register and one-deep command buffer
// behind an apb slave, with the two interrupt request levels.
// assumes: the array side gives protect_hit and verify_blank as levels and
// cpu_stop as a one-cycle strobe, all synchronous to pclk.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - buffer-empty bit 7; write one launches
// - zero write mid-sequence aborts, sets access error
// - zero write never changes buffer-empty flag
// - buffer-empty with enable requests interrupt
// - complete clears on launch, sets when idle
// - burst chaining keeps complete flag cleared
// - complete flag ignores software writes
// - complete with enable requests interrupt
// - protected target sets violation; one clears
// - violation blocks launch and new sequence
// - access error on sequence, code, stop
// - access error clears only by one
// - access error blocks launch and sequence
// - blank reports erase verify result
// - blank clears on valid launch
// - special mode: one clears blank
// - fail sets on failed verify; one clears
// - other status bits read zero
// - command code bits 6:0; bit 7 zero
// - normal mode accepts five command codes
// - other codes set access error
// - reserved test register reads zero
// - launch without divider write errors out
// - enabled buffer-empty raises request
module fcsl_core
  import fcsl_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // array side
  input wire logic protect_hit,
  input wire logic verify_blank,
  input wire logic cpu_stop,
  output logic array_busy,
  // interrupt requests
  output logic irq_buffer_empty,
  output logic irq_command_complete
);

  typedef struct packed {
    fcsl_seq_t seq;
    logic [6:0] cmd;
    logic pend_v;
    logic [6:0] pend;
    logic act_v;
    logic [6:0] act;
    logic div_ld;
    logic [6:0] div;
    logic be_ie;
    logic cc_ie;
    logic special;
    logic [31:0] rdata;
    logic slverr;
  } fcsl_core_t;

  fcsl_core_t q, d;

  logic setup, wr, hit;
  logic [7:0] w;
  logic buffer_empty_flag, command_complete_flag;
  logic protection_violation_flag, access_error_flag, blank_flag, fail_flag;
  logic errs, launch, op_start, op_done;
  logic protection_violation_flag_set, protection_violation_flag_clr, acc_set, acc_clr;
  logic blank_set, blank_clr, fail_set, fail_clr;
  logic [7:0] status_rd;

  function automatic logic is_valid_cmd(input logic [6:0] c);
    is_valid_cmd = (c == CMD_ERASE_VERIFY) || (c == CMD_PROGRAM) || (c == CMD_BURST_PROGRAM) ||
                   (c == CMD_SECTOR_ERASE) || (c == CMD_MASS_ERASE);
  endfunction

  // ----------------------------------------------------------------
  // flags and operation timer
  // ----------------------------------------------------------------
  fcsl_sticky_flag u_protection_violation_flag (
    .pclk(pclk), .presetn(presetn), .set(protection_violation_flag_set), .clr(protection_violation_flag_clr), .flag(protection_violation_flag)
  );
  fcsl_sticky_flag u_access_error_flag (
    .pclk(pclk), .presetn(presetn), .set(acc_set), .clr(acc_clr), .flag(access_error_flag)
  );
  fcsl_sticky_flag u_blank (
    .pclk(pclk), .presetn(presetn), .set(blank_set), .clr(blank_clr), .flag(blank_flag)
  );
  fcsl_sticky_flag u_fail (
    .pclk(pclk), .presetn(presetn), .set(fail_set), .clr(fail_clr), .flag(fail_flag)
  );
  fcsl_op_timer u_timer (
    .pclk(pclk), .presetn(presetn), .start(op_start), .done(op_done), .busy()
  );

  // ----------------------------------------------------------------
  // bus decode and status view
  // ----------------------------------------------------------------
  assign setup = psel & ~penable;
  // zero-wait slave; writes land at the access edge
  assign wr = psel & penable & pwrite & pstrb[0];
  assign w = pwdata[7:0];
  assign hit = (paddr == ADDR_STATUS) || (paddr == ADDR_COMMAND) || (paddr == ADDR_RSV_ONE) ||
               (paddr == ADDR_CONFIG) || (paddr == ADDR_CLKDIV) || (paddr == ADDR_ARRAY);

  assign buffer_empty_flag = ~q.pend_v;
  assign command_complete_flag = ~q.pend_v & ~q.act_v;
  assign errs = protection_violation_flag | access_error_flag;

  always_comb begin
    status_rd = 8'h00;
    status_rd[BIT_BUF_EMPTY] = buffer_empty_flag;
    status_rd[BIT_CMD_DONE] = command_complete_flag;
    status_rd[BIT_PROT_VIOL] = protection_violation_flag;
    status_rd[BIT_ACC_ERR] = access_error_flag;
    status_rd[BIT_BLANK] = blank_flag;
    status_rd[BIT_FAIL] = fail_flag;
  end

  // ----------------------------------------------------------------
  // sequencer, buffer and registers
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    launch = 1'b0;
    op_start = 1'b0;
    protection_violation_flag_set = 1'b0;
    acc_set = 1'b0;
    blank_set = 1'b0;
    fail_set = 1'b0;
    protection_violation_flag_clr = 1'b0;
    acc_clr = 1'b0;
    fail_clr = 1'b0;
    blank_clr = 1'b0;

    // finished command: erase verify reports its result with the complete flag
    if (q.act_v && op_done) begin
      d.act_v = 1'b0;
      if (q.act == CMD_ERASE_VERIFY) begin
        blank_set = verify_blank;
        fail_set = ~verify_blank;
      end
    end
    // pending command moves up as soon as the engine is free, so a burst
    // program never shows the complete flag between its words
    if (q.pend_v && (!q.act_v || op_done)) begin
      d.act_v = 1'b1;
      d.act = q.pend;
      d.pend_v = 1'b0;
      op_start = 1'b1;
    end

    if (wr) begin
      if (paddr == ADDR_STATUS) begin
        protection_violation_flag_clr = w[BIT_PROT_VIOL];
        acc_clr = w[BIT_ACC_ERR];
        fail_clr = w[BIT_FAIL];
        blank_clr = q.special & w[BIT_BLANK];
        if (w[BIT_BUF_EMPTY]) begin
          if (q.seq == SEQ_CMD && !errs && !q.pend_v) begin
            if (q.div_ld) begin
              launch = 1'b1;
              d.pend_v = 1'b1;
              d.pend = q.cmd;
            end else begin
              acc_set = 1'b1;
            end
            d.seq = SEQ_IDLE;
          end else if (q.seq != SEQ_IDLE) begin
            acc_set = 1'b1;
            d.seq = SEQ_IDLE;
          end
        end else if (q.seq != SEQ_IDLE) begin
          acc_set = 1'b1;
          d.seq = SEQ_IDLE;
        end
        // a zero write outside a sequence sets no flag
      end else if (paddr == ADDR_COMMAND) begin
        if (q.seq == SEQ_IDLE) begin
          acc_set = 1'b1;
        end else if (q.special || is_valid_cmd(w[6:0])) begin
          d.cmd = w[6:0];
          d.seq = SEQ_CMD;
        end else begin
          acc_set = 1'b1;
          d.seq = SEQ_IDLE;
        end
      end else if (paddr == ADDR_ARRAY) begin
        // blocked entirely while an error flag stands
        if (!errs) begin
          if (q.seq == SEQ_IDLE && !q.pend_v) begin
            if (protect_hit) begin
              protection_violation_flag_set = 1'b1;
            end else begin
              d.seq = SEQ_ADDR;
            end
          end else begin
            acc_set = 1'b1;
            d.seq = SEQ_IDLE;
          end
        end
      end else if (paddr == ADDR_CONFIG) begin
        d.be_ie = w[BIT_BE_IE];
        d.cc_ie = w[BIT_CC_IE];
        d.special = w[BIT_SPECIAL];
      end else if (paddr == ADDR_CLKDIV) begin
        d.div = w[6:0];
        d.div_ld = 1'b1;
      end
    end

    blank_clr = blank_clr | launch;
    if (cpu_stop && !command_complete_flag) begin
      acc_set = 1'b1;
    end

    // read data captured in the setup cycle, shown in the access cycle
    if (setup) begin
      d.slverr = ~hit;
      d.rdata = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == ADDR_STATUS) begin
          d.rdata[7:0] = status_rd;
        end else if (paddr == ADDR_COMMAND) begin
          d.rdata[7:0] = {1'b0, q.cmd};
        end else if (paddr == ADDR_CONFIG) begin
          d.rdata[BIT_BE_IE] = q.be_ie;
          d.rdata[BIT_CC_IE] = q.cc_ie;
          d.rdata[BIT_SPECIAL] = q.special;
        end else if (paddr == ADDR_CLKDIV) begin
          d.rdata[7:0] = {q.div_ld, q.div};
        end
        // reserved test register and array port read zero
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.seq <= SEQ_IDLE;
      q.cmd <= RST_COMMAND;
      q.div <= RST_CLKDIV;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & q.slverr;
  assign array_busy = q.act_v;
  // levels, so they drop the cycle a flag or enable goes low
  assign irq_buffer_empty = buffer_empty_flag & q.be_ie;
  assign irq_command_complete = command_complete_flag & q.cc_ie;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_status, wr_cmd, wr_array;
  assign wr_status = wr && (paddr == ADDR_STATUS);
  assign wr_cmd = wr && (paddr == ADDR_COMMAND);
  assign wr_array = wr && (paddr == ADDR_ARRAY);

  chk_launch_flags: assert property (
    launch |=> !command_complete_flag && !blank_flag)
    else $error("launch did not clear complete or blank");
  chk_abort_error: assert property (
    wr_status && !w[BIT_BUF_EMPTY] && q.seq != SEQ_IDLE |=> access_error_flag && q.seq == SEQ_IDLE)
    else $error("zero write mid-sequence did not abort");
  chk_zero_idle: assert property (
    wr_status && w == 8'h00 && q.seq == SEQ_IDLE && !cpu_stop |=> access_error_flag == $past(access_error_flag))
    else $error("idle zero write changed access error");
  chk_bad_code: assert property (
    wr_cmd && q.seq != SEQ_IDLE && !q.special && !is_valid_cmd(w[6:0]) |=> access_error_flag)
    else $error("illegal code accepted");
  chk_err_blocks: assert property (
    wr_array && errs && q.seq == SEQ_IDLE && !q.pend_v |=> q.seq == SEQ_IDLE && !q.pend_v)
    else $error("sequence started under error");
  chk_prot_sets: assert property (
    wr_array && !errs && q.seq == SEQ_IDLE && !q.pend_v && protect_hit |=> protection_violation_flag)
    else $error("protected write did not flag");
  chk_no_div: assert property (
    wr_status && w[BIT_BUF_EMPTY] && q.seq == SEQ_CMD && !q.div_ld && !errs |=> access_error_flag && !q.pend_v)
    else $error("launch executed without divider");
  chk_done_sets: assert property (
    q.act_v && !q.pend_v && !launch ##1 !q.act_v |-> command_complete_flag)
    else $error("complete flag missing after last command");
  chk_verify_res: assert property (
    q.act_v && op_done && q.act == CMD_ERASE_VERIFY && !verify_blank |=> fail_flag && command_complete_flag)
    else $error("failed verify not reported");
  chk_irq_drop: assert property (
    $fell(q.cc_ie) |-> !irq_command_complete)
    else $error("request stayed after enable cleared");
  chk_cmd_bit7: assert property (
    setup && !pwrite && paddr == ADDR_COMMAND |=> prdata[7] == 1'b0)
    else $error("command bit 7 read nonzero");
  chk_rsv_zero: assert property (
    setup && !pwrite && paddr == ADDR_RSV_ONE |=> prdata == 32'h0000_0000)
    else $error("reserved register read nonzero");
  chk_stop_error: assert property (
    cpu_stop && !command_complete_flag |=> access_error_flag)
    else $error("stop while busy did not flag");
  chk_multi_clear: assert property (
    wr_status && w[BIT_PROT_VIOL] && w[BIT_ACC_ERR] && !protection_violation_flag_set && !acc_set |=>
      !protection_violation_flag && !access_error_flag)
    else $error("multi-bit clear missed a flag");
  chk_blank_normal: assert property (
    wr_status && !q.special && w[BIT_BLANK] && blank_flag && !launch |=> blank_flag)
    else $error("blank cleared by a normal-mode write");
  chk_blank_special: assert property (
    wr_status && q.special && w[BIT_BLANK] && !blank_set |=> !blank_flag)
    else $error("special-mode write did not clear blank");
  chk_chain_cc: assert property (
    q.act_v && q.pend_v && op_done |=> !command_complete_flag)
    else $error("complete flag rose between chained commands");
  chk_cc_ignores: assert property (
    wr_status && w == 8'h40 && command_complete_flag |=> command_complete_flag)
    else $error("software write changed complete flag");
  chk_launch_full: assert property (
    launch |=> !buffer_empty_flag)
    else $error("launch did not fill the buffer");
  chk_fail_clear: assert property (
    wr_status && w[BIT_FAIL] && !fail_set |=> !fail_flag)
    else $error("one write did not clear fail");

  cov_launch: cover property (launch ##[1:40] command_complete_flag);
  cov_burst: cover property (q.act_v && q.pend_v && op_done);
  cov_abort: cover property (wr_status && !w[BIT_BUF_EMPTY] && q.seq == SEQ_CMD);
  cov_blank: cover property (blank_set);
  cov_special: cover property (wr_cmd && q.special && !is_valid_cmd(w[6:0]));

endmodule
`default_nettype wire

// >>> core/fcsl_op_timer.sv
// fcsl_op_timer: stand-in for the array algorithm duration of one command.
// assumes: start is a one-cycle strobe; a restart reloads the count.
`timescale 1ns/10ps
`default_nettype none
module fcsl_op_timer
  import fcsl_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  // status
  output logic done,
  output logic busy
);

  typedef struct packed {
    logic [7:0] cnt;
  } fcsl_timer_t;

  fcsl_timer_t q, d;

  always_comb begin
    d = q;
    if (start) begin
      d.cnt = OP_CYCLES;
    end else if (q.cnt != 8'h00) begin
      d.cnt = q.cnt - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = (q.cnt == 8'h01);
  assign busy = (q.cnt != 8'h00);

endmodule
`default_nettype wire

// >>> core/fcsl_pkg.sv
// fcsl_pkg: register map, field positions, command codes and sequencer states
// of the flash command and status logic.
// assumes: 32-bit apb, every register one aligned word at four times its index.
package fcsl_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_STATUS = 10'h105;
  localparam logic [9:0] IDX_COMMAND = 10'h106;
  localparam logic [9:0] IDX_RSV_ONE = 10'h107;
  localparam logic [9:0] IDX_CONFIG = 10'h110;
  localparam logic [9:0] IDX_CLKDIV = 10'h111;
  localparam logic [9:0] IDX_ARRAY = 10'h112;
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_COMMAND = {IDX_COMMAND, 2'b00};
  localparam logic [11:0] ADDR_RSV_ONE = {IDX_RSV_ONE, 2'b00};
  localparam logic [11:0] ADDR_CONFIG = {IDX_CONFIG, 2'b00};
  localparam logic [11:0] ADDR_CLKDIV = {IDX_CLKDIV, 2'b00};
  localparam logic [11:0] ADDR_ARRAY = {IDX_ARRAY, 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_BUF_EMPTY = 7;
  localparam int unsigned BIT_CMD_DONE = 6;
  localparam int unsigned BIT_PROT_VIOL = 5;
  localparam int unsigned BIT_ACC_ERR = 4;
  localparam int unsigned BIT_BLANK = 2;
  localparam int unsigned BIT_FAIL = 1;
  localparam int unsigned BIT_BE_IE = 7;
  localparam int unsigned BIT_CC_IE = 6;
  localparam int unsigned BIT_SPECIAL = 0;
  localparam int unsigned BIT_DIV_LOADED = 7;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_ERASE_VERIFY = 7'h05;
  localparam logic [6:0] CMD_PROGRAM = 7'h20;
  localparam logic [6:0] CMD_BURST_PROGRAM = 7'h25;
  localparam logic [6:0] CMD_SECTOR_ERASE = 7'h40;
  localparam logic [6:0] CMD_MASS_ERASE = 7'h41;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] RST_COMMAND = 7'h00;
  localparam logic [6:0] RST_CLKDIV = 7'h00;
  localparam logic [7:0] OP_CYCLES = 8'h10;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fcsl_seq_t;

endpackage

// >>> core/fcsl_sticky_flag.sv
// fcsl_sticky_flag: one status flag set by hardware, cleared by software.
// assumes: set and clear are single-cycle strobes on pclk.
`timescale 1ns/10ps
`default_nettype none
module fcsl_sticky_flag
  import fcsl_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic flag
);

  typedef struct packed {
    logic f;
  } fcsl_flag_t;

  fcsl_flag_t q, d;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    d = q;
    d.f = set | (q.f & ~clr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flag = q.f;

endmodule
`default_nettype wire
